// file: verilog/floppy_host_register_port.sv
// host register port of the floppy controller: address decode, drive
// control, configuration gate, software reset and dma/irq pin gating
// assumes the controller core runs on clk_sys and answers a read request
// with core_rd_data in the same cycle as core_req.rd
//
// Contract
// - registers are eight bits, single cycles
// - access by programmed io and dma
// - offsets decoded from base address 3f0
// - +2,+3 rw, +5 fifo, +0 +1 status read, +6 reserved
// - +4 status/rate, +7 input/rate control
// - all offsets disabled until configuration enables
// - config +0/+1 write only, config mode
// - config mode blocks status a and b
// - drive control field layout, resets to zero
// - drive control always writable, kept on reset; here writable only when enabled, not in a dma cycle
// - drive select binary decoded, one drive
// - bit2 zero holds core reset until one
// - soft reset keeps rate and control registers
// - soft reset honoured at 100ns minimum
// - dma enable drives request, irq, accepts inputs
// - dma disabled floats outputs, ignores inputs
// - motor bits drive spindle outputs active
`timescale 1ns/10ps
module floppy_host_register_port #(
  parameter logic [fdc_port_pkg::ADDR_W-1:0] BASE_ADDR =
    fdc_port_pkg::BASE_ADDR_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire fdc_port_pkg::host_bus_type host_pins,
  output logic [fdc_port_pkg::DATA_W-1:0] bus_data_out,
  output logic bus_data_oe_n,
  input wire logic config_mode_pin,
  input wire logic dma_grant_n,
  input wire logic terminal_count_in,
  output fdc_port_pkg::core_req_type core_req,
  input wire logic [fdc_port_pkg::DATA_W-1:0] core_rd_data,
  input wire logic core_dma_req,
  input wire logic core_irq,
  output logic core_dma_grant,
  output logic core_terminal_count,
  output logic core_reset_n,
  output logic [fdc_port_pkg::DATA_W-1:0] rate_select_out,
  output logic [fdc_port_pkg::DATA_W-1:0] transfer_rate_out,
  output logic dma_req_out,
  output logic dma_req_oe_n,
  output logic irq_out,
  output logic irq_oe_n,
  output logic [3:0] drive_pick_outputs,
  output logic [3:0] drive_pick_oe_n,
  output logic [3:0] spindle_out,
  output logic [3:0] spindle_oe_n
);
  import fdc_port_pkg::*;

  host_bus_type bus_s;
  logic [2:0] misc_s;
  logic cfg_mode_s;
  logic grant_n_s;
  logic tc_s;

  logic rd_prev_ff;
  logic wr_prev_ff;
  logic rd_start;
  logic wr_start;
  logic rd_end;
  logic addr_hit;
  logic [OFS_W-1:0] ofs;
  logic dma_cycle;

  logic [DATA_W-1:0] drive_control_reg_ff;
  logic [DATA_W-1:0] tape_select_reg_ff;
  logic [DATA_W-1:0] rate_select_ff;
  logic [DATA_W-1:0] transfer_rate_control_reg_ff;
  logic [DATA_W-1:0] cfg_index_ff;
  logic cfg_enable_ff;
  logic [SRST_CNT_W-1:0] srst_cnt_ff;
  logic core_rd_wait_ff;

  logic dma_irq_output_enable;
  logic soft_reset_n;
  logic drive_pick_0;
  logic drive_pick_1;
  logic motor_on_0;
  logic motor_on_1;
  logic motor_on_2;
  logic motor_on_3;

  // a single host-visible offset is live only when the block is enabled;
  // status a and b are also shut while configuration mode is on
  function automatic logic reg_live(input logic [OFS_W-1:0] o,
                                    input logic enabled,
                                    input logic in_cfg,
                                    input logic is_read);
    logic live;
    live = enabled;
    if (is_read && in_cfg &&
        (o == OFS_STATUS_A || o == OFS_STATUS_B)) begin
      live = 1'b0;
    end
    if (o == OFS_RESERVED) begin
      live = 1'b0;
    end
    if (!is_read && (o == OFS_CFG_INDEX || o == OFS_CFG_DATA)) begin
      live = 1'b0;
    end
    return live;
  endfunction : reg_live

  pin_sync #(
    .WIDTH($bits(host_bus_type)),
    .RESET_VAL({2'b11, {(ADDR_W + DATA_W){1'b0}}})
  ) u_bus_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .pin_in(host_pins),
    .pin_out(bus_s)
  );

  pin_sync #(
    .WIDTH(3),
    .RESET_VAL(3'b010)
  ) u_misc_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .pin_in({config_mode_pin, dma_grant_n, terminal_count_in}),
    .pin_out(misc_s)
  );

  assign cfg_mode_s = misc_s[2];
  assign grant_n_s = misc_s[1];
  assign tc_s = misc_s[0];

  assign motor_on_3 = drive_control_reg_ff[DC_MOTOR_LSB + 3];
  assign motor_on_2 = drive_control_reg_ff[DC_MOTOR_LSB + 2];
  assign motor_on_1 = drive_control_reg_ff[DC_MOTOR_LSB + 1];
  assign motor_on_0 = drive_control_reg_ff[DC_MOTOR_LSB];
  assign dma_irq_output_enable = drive_control_reg_ff[DC_DMA_EN];
  assign soft_reset_n = drive_control_reg_ff[DC_SOFT_RESET_N];
  assign drive_pick_1 = drive_control_reg_ff[DC_DRIVE_PICK_LSB + 1];
  assign drive_pick_0 = drive_control_reg_ff[DC_DRIVE_PICK_LSB];

  // strobes are acted on once, at the first synchronised edge
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rd_prev_ff <= 1'b0;
      wr_prev_ff <= 1'b0;
    end else begin
      rd_prev_ff <= ~bus_s.rd_n;
      wr_prev_ff <= ~bus_s.wr_n;
    end
  end

  assign rd_start = ~bus_s.rd_n & ~rd_prev_ff;
  assign wr_start = ~bus_s.wr_n & ~wr_prev_ff;
  assign rd_end = bus_s.rd_n & rd_prev_ff;
  assign addr_hit = bus_s.addr[ADDR_W-1:OFS_W] ==
                    BASE_ADDR[ADDR_W-1:OFS_W];
  assign ofs = bus_s.addr[OFS_W-1:0];
  // a granted dma cycle targets the data fifo whatever the address
  assign dma_cycle = dma_irq_output_enable & ~grant_n_s &
                     cfg_enable_ff;

  // configuration space: writable only in configuration mode
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cfg_index_ff <= CFG_INDEX_RESET;
      cfg_enable_ff <= CFG_ENABLE_RESET;
    end else if (wr_start && !dma_cycle && addr_hit && cfg_mode_s) begin
      if (ofs == OFS_CFG_INDEX) begin
        cfg_index_ff <= bus_s.data;
      end else if (ofs == OFS_CFG_DATA && cfg_index_ff == CFG_IDX_ENABLE)
      begin
        cfg_enable_ff <= bus_s.data[CFG_ENABLE_BIT];
      end
    end
  end

  // drive control: written whenever live outside a dma cycle, never touched by soft reset
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      drive_control_reg_ff <= DRIVE_CONTROL_RESET;
    end else if (wr_start && !dma_cycle && addr_hit &&
                 ofs == OFS_DRIVE_CONTROL &&
                 reg_live(ofs, cfg_enable_ff, cfg_mode_s, 1'b0)) begin
      drive_control_reg_ff <= bus_s.data;
    end
  end

  // only the two select bits of the tape register are stored
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      tape_select_reg_ff <= TAPE_SELECT_RESET;
    end else if (wr_start && !dma_cycle && addr_hit &&
                 ofs == OFS_TAPE_SELECT &&
                 reg_live(ofs, cfg_enable_ff, cfg_mode_s, 1'b0)) begin
      tape_select_reg_ff <= bus_s.data & TAPE_SELECT_MASK;
    end
  end

  // write-only rate registers share offsets with read-only status; they
  // sit here rather than in the core so soft reset cannot reach them
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rate_select_ff <= RATE_SELECT_RESET;
      transfer_rate_control_reg_ff <= TRANSFER_RATE_RESET;
    end else if (wr_start && !dma_cycle && addr_hit &&
                 reg_live(ofs, cfg_enable_ff, cfg_mode_s, 1'b0)) begin
      if (ofs == OFS_RATE_SELECT) begin
        rate_select_ff <= bus_s.data;
      end
      if (ofs == OFS_TRANSFER_RATE) begin
        transfer_rate_control_reg_ff <= bus_s.data;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rate_select_out <= RATE_SELECT_RESET;
      transfer_rate_out <= TRANSFER_RATE_RESET;
    end else begin
      rate_select_out <= rate_select_ff;
      transfer_rate_out <= transfer_rate_control_reg_ff;
    end
  end

  // requests passed to the core: fifo data, status reads, core reads
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      core_req <= '0;
    end else begin
      core_req.rd <= 1'b0;
      core_req.wr <= 1'b0;
      if (wr_start && dma_cycle) begin
        core_req.wr <= 1'b1;
        core_req.offset <= OFS_DATA_FIFO;
        core_req.data <= bus_s.data;
      end else if (wr_start && addr_hit && ofs == OFS_DATA_FIFO &&
                   reg_live(ofs, cfg_enable_ff, cfg_mode_s, 1'b0)) begin
        core_req.wr <= 1'b1;
        core_req.offset <= OFS_DATA_FIFO;
        core_req.data <= bus_s.data;
      end else if (rd_start && dma_cycle) begin
        core_req.rd <= 1'b1;
        core_req.offset <= OFS_DATA_FIFO;
      end else if (rd_start && addr_hit &&
                   reg_live(ofs, cfg_enable_ff, cfg_mode_s, 1'b1) &&
                   ofs != OFS_DRIVE_CONTROL && ofs != OFS_TAPE_SELECT) begin
        core_req.rd <= 1'b1;
        core_req.offset <= ofs;
      end
    end
  end

  // read data: local registers answer at once, core ones a cycle later
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      core_rd_wait_ff <= 1'b0;
      bus_data_out <= '0;
    end else begin
      core_rd_wait_ff <= 1'b0;
      if (core_rd_wait_ff) begin
        bus_data_out <= core_rd_data;
      end else if (rd_start && !dma_cycle && addr_hit &&
                   reg_live(ofs, cfg_enable_ff, cfg_mode_s, 1'b1)) begin
        if (ofs == OFS_DRIVE_CONTROL) begin
          bus_data_out <= drive_control_reg_ff;
        end else if (ofs == OFS_TAPE_SELECT) begin
          bus_data_out <= tape_select_reg_ff;
        end else begin
          core_rd_wait_ff <= 1'b1;
        end
      end else if (rd_start && dma_cycle) begin
        core_rd_wait_ff <= 1'b1;
      end
    end
  end

  // the data bus is driven only for a live read, until the strobe ends;
  // a dead offset leaves the bus floating as an absent device would
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      bus_data_oe_n <= 1'b1;
    end else if (rd_end) begin
      bus_data_oe_n <= 1'b1;
    end else if (rd_start && (dma_cycle || (addr_hit &&
                 reg_live(ofs, cfg_enable_ff, cfg_mode_s, 1'b1)))) begin
      bus_data_oe_n <= 1'b0;
    end
  end

  // core reset follows bit 2 and is stretched to the minimum width, so
  // two back-to-back writes still give the core a full reset
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      srst_cnt_ff <= SRST_CNT_W'(SOFT_RESET_CYCLES);
    end else if (!soft_reset_n) begin
      srst_cnt_ff <= SRST_CNT_W'(SOFT_RESET_CYCLES);
    end else if (srst_cnt_ff != '0) begin
      srst_cnt_ff <= srst_cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      core_reset_n <= 1'b0;
    end else begin
      core_reset_n <= soft_reset_n && srst_cnt_ff == '0;
    end
  end

  // dma and interrupt pins: driven only while enabled, else floated
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      dma_req_out <= 1'b0;
      dma_req_oe_n <= 1'b1;
      irq_out <= 1'b0;
      irq_oe_n <= 1'b1;
    end else begin
      dma_req_out <= core_dma_req;
      irq_out <= core_irq;
      dma_req_oe_n <= ~dma_irq_output_enable;
      irq_oe_n <= ~dma_irq_output_enable;
    end
  end

  // acknowledge and terminal count reach the core only while enabled
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      core_dma_grant <= 1'b0;
      core_terminal_count <= 1'b0;
    end else begin
      core_dma_grant <= dma_irq_output_enable & ~grant_n_s;
      core_terminal_count <= dma_irq_output_enable & tc_s;
    end
  end

  drive_line_driver u_drive_lines (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .drive_pick({drive_pick_1, drive_pick_0}),
    .motor_on({motor_on_3, motor_on_2, motor_on_1, motor_on_0}),
    .drive_pick_outputs(drive_pick_outputs),
    .drive_pick_oe_n(drive_pick_oe_n),
    .spindle_out(spindle_out),
    .spindle_oe_n(spindle_oe_n)
  );

endmodule : floppy_host_register_port

// file: verilog/fdc_port_pkg.sv
// register map, field layout and carrier types of the host register port
// assumes a single core clock; pin timing figures are turned into cycles here
package fdc_port_pkg;

  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int OFS_W = 3;
  localparam logic [ADDR_W-1:0] BASE_ADDR_DEFAULT = 10'h3f0;

  // offsets relative to the base address; some are shared by read and write
  localparam logic [OFS_W-1:0] OFS_CFG_INDEX = 3'h0;
  localparam logic [OFS_W-1:0] OFS_CFG_DATA = 3'h1;
  localparam logic [OFS_W-1:0] OFS_STATUS_A = 3'h0;
  localparam logic [OFS_W-1:0] OFS_STATUS_B = 3'h1;
  localparam logic [OFS_W-1:0] OFS_DRIVE_CONTROL = 3'h2;
  localparam logic [OFS_W-1:0] OFS_TAPE_SELECT = 3'h3;
  localparam logic [OFS_W-1:0] OFS_MAIN_STATUS = 3'h4;
  localparam logic [OFS_W-1:0] OFS_RATE_SELECT = 3'h4;
  localparam logic [OFS_W-1:0] OFS_DATA_FIFO = 3'h5;
  localparam logic [OFS_W-1:0] OFS_RESERVED = 3'h6;
  localparam logic [OFS_W-1:0] OFS_DRIVE_INPUT = 3'h7;
  localparam logic [OFS_W-1:0] OFS_TRANSFER_RATE = 3'h7;

  // drive_control field positions
  localparam int DC_DRIVE_PICK_LSB = 0;
  localparam int DC_SOFT_RESET_N = 2;
  localparam int DC_DMA_EN = 3;
  localparam int DC_MOTOR_LSB = 4;

  localparam logic [DATA_W-1:0] DRIVE_CONTROL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] TAPE_SELECT_RESET = 8'h00;
  localparam logic [DATA_W-1:0] TAPE_SELECT_MASK = 8'h03;
  localparam logic [DATA_W-1:0] RATE_SELECT_RESET = 8'h00;
  localparam logic [DATA_W-1:0] TRANSFER_RATE_RESET = 8'h00;

  // configuration space: one index register, one enable register
  localparam logic [DATA_W-1:0] CFG_IDX_ENABLE = 8'h00;
  localparam int CFG_ENABLE_BIT = 0;
  localparam logic CFG_ENABLE_RESET = 1'b0;
  localparam logic [DATA_W-1:0] CFG_INDEX_RESET = 8'h00;

  // shortest core reset the host may rely on
  localparam int CLK_PERIOD_NS = 10;
  localparam int SOFT_RESET_MIN_NS = 100;
  localparam int SOFT_RESET_CYCLES =
    (SOFT_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SRST_CNT_W = 4;

  typedef struct packed {
    logic rd_n;
    logic wr_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } host_bus_type;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [OFS_W-1:0] offset;
    logic [DATA_W-1:0] data;
  } core_req_type;

endpackage : fdc_port_pkg

// file: verilog/pin_sync.sv
// three-stage synchroniser for a group of pins
// assumes inputs are asynchronous to clk_sys; a change is passed once the
// second and third stage agree, otherwise the last accepted value is held
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);

  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;
  logic [WIDTH-1:0] stage3_ff;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      stage1_ff <= RESET_VAL;
      stage2_ff <= RESET_VAL;
      stage3_ff <= RESET_VAL;
    end else begin
      stage1_ff <= pin_in;
      stage2_ff <= stage1_ff;
      stage3_ff <= stage2_ff;
    end
  end

  // bitwise: a bit that still disagrees keeps its previous accepted value
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pin_out <= RESET_VAL;
    end else begin
      pin_out <= (stage2_ff & stage3_ff) |
                 (pin_out & (stage2_ff | stage3_ff));
    end
  end

endmodule : pin_sync

// file: verilog/drive_line_driver.sv
// registered open-drain drivers for drive pick and spindle lines
// assumes the lines are pulled up off chip; a low enable pulls a line low
`timescale 1ns/10ps
module drive_line_driver (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [1:0] drive_pick,
  input wire logic [3:0] motor_on,
  output logic [3:0] drive_pick_outputs,
  output logic [3:0] drive_pick_oe_n,
  output logic [3:0] spindle_out,
  output logic [3:0] spindle_oe_n
);

  // registered so a host write never glitches the drive cable
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      drive_pick_oe_n <= 4'he;
      spindle_oe_n <= 4'hf;
    end else begin
      drive_pick_oe_n <= ~(4'h1 << drive_pick);
      spindle_oe_n <= ~motor_on;
    end
  end

  // the driven level of an open-drain pin is always low
  always_ff @(posedge clk_sys) begin
    drive_pick_outputs <= 4'h0;
    spindle_out <= 4'h0;
  end

endmodule : drive_line_driver

// file: bench/fdc_port_chk.sv
// concurrent checks on the host register port pins
// assumes it is bound to the port's top module, ports matched by name
`timescale 1ns/10ps
module fdc_port_chk (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire fdc_port_pkg::host_bus_type host_pins,
  input wire logic bus_data_oe_n,
  input wire logic config_mode_pin,
  input wire fdc_port_pkg::core_req_type core_req,
  input wire logic core_reset_n,
  input wire logic core_dma_grant,
  input wire logic core_terminal_count,
  input wire logic core_dma_req,
  input wire logic core_irq,
  input wire logic dma_req_out,
  input wire logic irq_out,
  input wire logic dma_req_oe_n,
  input wire logic irq_oe_n,
  input wire logic [3:0] drive_pick_oe_n,
  input wire logic [3:0] spindle_oe_n
);
  import fdc_port_pkg::*;
  logic [3:0] low_cnt_ff;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // saturating, so a long core reset cannot wrap into a short one
  always_ff @(posedge clk_sys) begin
    if (!reset_n || core_reset_n) begin
      low_cnt_ff <= 4'h0;
    end else if (low_cnt_ff != 4'hf) begin
      low_cnt_ff <= low_cnt_ff + 4'h1;
    end
  end
  property p_rst_vals;
    $rose(reset_n) |-> drive_pick_oe_n == 4'he && spindle_oe_n == 4'hf &&
      !core_reset_n && bus_data_oe_n && dma_req_oe_n;
  endproperty
  a_rst_vals: assert property (p_rst_vals)
    else $error("reset values wrong");
  property p_pick_one;
    $onehot(~drive_pick_oe_n);
  endproperty
  a_pick_one: assert property (p_pick_one)
    else $error("drive pick not one-hot");
  property p_bus_idle;
    host_pins.rd_n [*8] |-> bus_data_oe_n;
  endproperty
  a_bus_idle: assert property (p_bus_idle)
    else $error("data bus driven without a read");
  property p_cfg_block;
    config_mode_pin [*8] |->
      !(core_req.rd && core_req.offset inside {3'h0, 3'h1});
  endproperty
  a_cfg_block: assert property (p_cfg_block)
    else $error("status a or b read in config mode");
  property p_drive_quiet;
    host_pins.wr_n [*8] |-> $stable(drive_pick_oe_n) && $stable(spindle_oe_n);
  endproperty
  a_drive_quiet: assert property (p_drive_quiet)
    else $error("drive lines moved without a write");
  property p_rst_len;
    $rose(core_reset_n) |-> low_cnt_ff >= 4'ha;
  endproperty
  a_rst_len: assert property (p_rst_len)
    else $error("core reset too short");
  property p_irq_oe;
    irq_oe_n == dma_req_oe_n && (dma_req_oe_n ||
      (dma_req_out == $past(core_dma_req) && irq_out == $past(core_irq)));
  endproperty
  a_irq_oe: assert property (p_irq_oe)
    else $error("irq and request enables differ");
  property p_dma_off;
    dma_req_oe_n && $past(dma_req_oe_n) |-> !core_dma_grant &&
      !core_terminal_count;
  endproperty
  a_dma_off: assert property (p_dma_off)
    else $error("dma inputs passed while disabled");
  property p_core_pulse;
    core_req.rd || core_req.wr |=> !core_req.rd && !core_req.wr;
  endproperty
  a_core_pulse: assert property (p_core_pulse)
    else $error("core request longer than one cycle");
endmodule : fdc_port_chk

bind floppy_host_register_port fdc_port_chk u_chk (.*);

// file: bench/host_model.sv
// host processor model driving the raw host pins
// assumes the port acts on a strobe about four clocks after the pin moves
`timescale 1ns/10ps
module host_model (
  input wire logic clk_sys,
  input wire logic [7:0] bus_data_out,
  input wire logic bus_data_oe_n,
  output fdc_port_pkg::host_bus_type host_pins
);
  import fdc_port_pkg::*;
  initial begin
    host_pins = '{rd_n: 1'b1, wr_n: 1'b1, addr: 10'h000, data: 8'h00};
  end
  // strobe held 8 clocks, then 14 idle clocks for the sync chain
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    host_pins <= '{rd_n: 1'b1, wr_n: 1'b0, addr: a, data: d};
    repeat (8) @(posedge clk_sys);
    host_pins.wr_n <= 1'b1;
    repeat (14) @(posedge clk_sys);
    host_pins.data <= ~d;
  endtask : wr
  // released data lines show the inverse, never a stale copy
  task automatic rd(input logic [9:0] a, output logic [7:0] d,
                    output logic drv);
    @(posedge clk_sys);
    host_pins <= '{rd_n: 1'b0, wr_n: 1'b1, addr: a,
                   data: ~host_pins.data};
    drv = 1'b0;
    repeat (8) begin
      @(posedge clk_sys);
      #1;
      if (bus_data_oe_n === 1'b0) drv = 1'b1;
    end
    d = bus_data_out;
    // strobe is let go only at an edge, after the data has been taken
    @(posedge clk_sys);
    host_pins.rd_n <= 1'b1;
    repeat (13) @(posedge clk_sys);
  endtask : rd
endmodule : host_model

// file: bench/tb_top.sv
// self-checking bench for the host register port
// assumes host_model on the host pins and a small core stub in here
`timescale 1ns/10ps
module tb_top;
  import fdc_port_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  host_bus_type host_pins;
  core_req_type core_req;
  logic [7:0] bus_data_out, rate_select_out, transfer_rate_out;
  logic [7:0] core_rd_data;
  logic bus_data_oe_n, core_dma_grant, core_terminal_count, core_reset_n;
  logic dma_req_out, dma_req_oe_n, irq_out, irq_oe_n, drv;
  logic config_mode_pin = 1'b0;
  logic dma_grant_n = 1'b1;
  logic terminal_count_in = 1'b0;
  logic core_dma_req = 1'b0;
  logic core_irq = 1'b0;
  logic [3:0] drive_pick_outputs, drive_pick_oe_n, spindle_out, spindle_oe_n;
  logic [31:0] seed = 32'he0f9;
  logic [31:0] v;
  logic [7:0] d;
  logic [10:0] cw_q[$];
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int dc_m = 0;
  int rate_m = 0;
  int xfer_m = 0;
  int act[4] = '{8'h1c, 8'h2d, 8'h4e, 8'h8f};

  floppy_host_register_port u_dut (.*);
  host_model u_host (.*);

  always #5 clk_sys = ~clk_sys;

  // core stub: read data names the offset that was asked for; it answers
  // at once, since the port takes it while the request still stands
  assign core_rd_data = {5'h15, core_req.offset};
  always @(posedge clk_sys) begin
    if (core_req.wr) cw_q.push_back({core_req.offset, core_req.data});
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      end_sim();
    end
  end

  function automatic logic [31:0] nxt();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : nxt

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_pins();
    chk(drive_pick_oe_n, 4'(~(4'h1 << dc_m[1:0])));
    chk(spindle_oe_n, 4'(~dc_m[7:4]));
    chk(core_reset_n, dc_m[2]);
    chk({dma_req_oe_n, irq_oe_n}, {2{~dc_m[3]}});
    chk(rate_select_out, rate_m);
    chk(transfer_rate_out, xfer_m);
    chk({drive_pick_outputs, spindle_out}, 8'h00);
  endtask : chk_pins

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim

  initial begin
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk_pins();
    u_host.wr(10'h3f2, 8'h1c);
    u_host.rd(10'h3f2, d, drv);
    chk(drv, 1'b0);
    chk_pins();
    $display("test disabled done");
    config_mode_pin <= 1'b1;
    u_host.wr(10'h3f0, CFG_IDX_ENABLE);
    u_host.wr(10'h3f1, 8'h01);
    u_host.rd(10'h3f0, d, drv);
    chk(drv, 1'b0);
    config_mode_pin <= 1'b0;
    repeat (8) @(posedge clk_sys);
    u_host.wr(10'h3f1, 8'h00);
    u_host.rd(10'h3f0, d, drv);
    chk(d, 8'ha8);
    $display("test config done");
    foreach (act[i]) begin
      dc_m = act[i];
      u_host.wr(10'h3f2, 8'(dc_m));
      u_host.rd(10'h3f2, d, drv);
      chk(d, dc_m);
      chk_pins();
    end
    v = nxt();
    rate_m = v[7:0];
    xfer_m = v[15:8];
    u_host.wr(10'h3f4, v[7:0]);
    u_host.wr(10'h3f7, v[15:8]);
    dc_m = 8'h8b;
    u_host.wr(10'h3f2, 8'h8b);
    chk_pins();
    dc_m = 8'h8f;
    u_host.wr(10'h3f2, 8'h8f);
    chk_pins();
    u_host.rd(10'h3f2, d, drv);
    chk(d, 8'h8f);
    $display("test soft reset done");
    u_host.wr(10'h3f3, 8'hff);
    u_host.rd(10'h3f3, d, drv);
    chk(d, 8'h03);
    for (int o = 4; o < 8; o++) begin
      u_host.rd(10'h3f0 + 10'(o), d, drv);
      chk(drv, o != 6);
      if (o != 6) chk(d, {5'h15, 3'(o)});
    end
    cw_q.delete();
    u_host.wr(10'h3f5, v[23:16]);
    u_host.wr(10'h3f6, v[31:24]);
    chk(cw_q.size(), 1);
    chk(cw_q.pop_front(), {3'h5, v[23:16]});
    u_host.wr(10'h372, 8'h10);
    chk_pins();
    $display("test decode done");
    for (int i = 0; i < 12; i++) begin
      v = nxt();
      dc_m = v[7:0];
      u_host.wr(10'h3f2, v[7:0]);
      core_dma_req <= v[8];
      core_irq <= v[9];
      dma_grant_n <= v[10];
      terminal_count_in <= v[11];
      repeat (8) @(posedge clk_sys);
      #1;
      chk_pins();
      chk({core_dma_grant, core_terminal_count},
          {2{v[3]}} & {~v[10], v[11]});
      if (v[3]) chk({dma_req_out, irq_out}, {v[8], v[9]});
      @(posedge clk_sys);
      dma_grant_n <= 1'b1;
      repeat (6) @(posedge clk_sys);
      u_host.rd(10'h3f2, d, drv);
      chk(d, dc_m);
    end
    $display("test random done");
    dc_m = 8'h1c;
    u_host.wr(10'h3f2, 8'h1c);
    dma_grant_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    cw_q.delete();
    u_host.wr(10'h3f2, 8'h00);
    chk(cw_q.size(), 1);
    chk(cw_q.pop_front(), {3'h5, 8'h00});
    u_host.rd(10'h3f2, d, drv);
    chk(d, 8'had);
    dma_grant_n <= 1'b1;
    #1;
    chk_pins();
    $display("test dma done");
    end_sim();
  end
endmodule : tb_top
